//--- hw/vmr_master_top.sv
/*
 * Bus master with two mapping windows, release-when-done requester,
 * bounded burst hold, byte lane swap and interrupter.
 * Assumes the local processor holds its request until acknowledged and
 * all bus pins and straps are asynchronous to clock_in.
 */
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
// Function
// - Bus address joins local low 16 bits with a 16-bit map value.
// - Local address bit 16 picks one of two map registers.
// - A32 mode drives modifier lines from the host-written modifier register.
// - A24 mode takes modifier from low six bits of map upper byte.
// - A24 mode also places that map byte on address lines 31-24.
// - A32 mode uses all sixteen map bits as address.
// - A24 or A32 chosen by a static strap input.
// - 8 or 16-bit transfers with automatic byte lane swapping.
// - No local memory on the bus; host passes one byte via slave port.
// - Normal mode releases the bus after each completed bus cycle.
// - Request on one of four levels; other grants pass straight through.
// - No requests while ACFAIL or SYSFAIL; local access waits meanwhile unless a burst already holds the bus.
// - Burst mode holds the bus at most 15 us, then re-arbitrates.
// - Burst mode ignores bus clear and other requests when releasing.
// - Burst drives a fresh address each cycle; enabled by static strap.
// - Interrupt on any of seven levels with a software-set 8-bit vector.
// - Slave access to control registers, byte wide only.
// - Host writes modifier byte; low six bits kept and driven in A32.
module vmr_master_top import vmr_pkg::*; (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic loc_req_in,
    input wire logic loc_we_in,
    input wire logic loc_byte_in,
    input wire logic [16:0] loc_addr_in,
    input wire logic [15:0] loc_wdata_in,
    output logic loc_ack_out,
    output logic [15:0] loc_rdata_out,
    input wire logic [2:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    output logic irq_out,
    input wire logic a24_master_strap_in,
    input wire logic burst_enable_strap_in,
    input wire logic [1:0] request_level_strap_in,
    input wire logic [3:0] vme_bgin_in,
    output logic [3:0] vme_bgout_out,
    output logic [3:0] vme_br_out,
    input wire logic vme_bbsy_in,
    output logic vme_bbsy_out,
    input wire logic vme_acfail_in,
    input wire logic vme_sysfail_in,
    output logic [31:0] vme_addr_out,
    output logic [5:0] vme_am_out,
    output logic vme_as_out,
    output logic [1:0] vme_ds_out,
    output logic vme_write_out,
    input wire logic [15:0] vme_data_in,
    output logic [15:0] vme_data_out,
    output logic vme_data_oe_out,
    input wire logic vme_dtack_in,
    input wire logic vme_berr_in,
    output logic vme_dtack_out,
    output logic [6:0] vme_irq_out,
    input wire logic vme_iack_in,
    input wire logic [2:0] vme_iack_lvl_in,
    input wire logic slv_wr_in,
    input wire logic slv_rd_in,
    input wire logic [2:0] slv_port_in,
    input wire logic [7:0] slv_data_in,
    output logic [7:0] slv_data_out
);
    localparam int SW = 46;
    typedef struct packed {
        vmr_state_t st;
        logic [3:0] br;
        logic [3:0] bgout;
        logic bbsy;
        logic [31:0] addr;
        logic [5:0] am;
        logic as;
        logic [1:0] ds;
        logic wr;
        logic [15:0] dout;
        logic doe;
        logic [16:0] laddr;
        logic lwe;
        logic lbyte;
        logic [15:0] lwdata;
        logic ack;
        logic [15:0] rdata;
        logic [11:0] btmr;
        logic [6:0] irq;
        logic vec_oe;
        logic dtack_o;
        logic iack_done;
        logic [3:0] ev;
    } vmr_core_t;

    vmr_core_t r;
    vmr_core_t next_r;
    vmr_cfg_if cfg();
    logic [SW-1:0] raw;
    logic [SW-1:0] syn;
    logic [3:0] bg_s;
    logic dtack_s;
    logic berr_s;
    logic acfail_s;
    logic sysfail_s;
    logic bbsy_s;
    logic iack_s;
    logic [2:0] iack_lvl_s;
    logic swr_s;
    logic srd_s;
    logic [2:0] sport_s;
    logic [7:0] sdata_s;
    logic [15:0] vdata_s;
    logic a24_s;
    logic burst_s;
    logic [1:0] lvl_s;
    logic fail;
    logic [15:0] map_sel;

    // Lane strobes: bit 1 is the even (upper) byte of the big-endian bus
    function automatic logic [1:0] lane_sel(input logic is_byte, input logic a0);
        lane_sel = is_byte ? (a0 ? 2'b01 : 2'b10) : 2'b11;
    endfunction

    function automatic logic [15:0] swap16(input logic [15:0] d);
        swap16 = {d[7:0], d[15:8]};
    endfunction

    assign raw = {vme_bgin_in, vme_dtack_in, vme_berr_in, vme_acfail_in,
        vme_sysfail_in, vme_bbsy_in, vme_iack_in, vme_iack_lvl_in, slv_wr_in,
        slv_rd_in, slv_port_in, slv_data_in, vme_data_in, a24_master_strap_in,
        burst_enable_strap_in, request_level_strap_in};
    assign {bg_s, dtack_s, berr_s, acfail_s, sysfail_s, bbsy_s, iack_s, iack_lvl_s,
        swr_s, srd_s, sport_s, sdata_s, vdata_s, a24_s, burst_s, lvl_s} = syn;

    vmr_sync #(.W(SW)) u_sync (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .raw_in(raw),
        .sync_out(syn)
    );

    vmr_regs u_regs (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .cfg(cfg.regs),
        .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out),
        .slv_wr_in(swr_s),
        .slv_rd_in(srd_s),
        .slv_port_in(sport_s),
        .slv_data_in(sdata_s),
        .slv_data_out(slv_data_out),
        .irq_out(irq_out)
    );

    assign fail = acfail_s || sysfail_s;
    assign map_sel = r.laddr[16] ? cfg.map1 : cfg.map0;

    always_comb begin
        next_r = r;
        next_r.ack = 1'b0;
        next_r.iack_done = 1'b0;
        next_r.ev = 4'h0;
        next_r.ev[EV_FAIL] = fail;
        if (r.bbsy && r.btmr != 12'h000) begin
            next_r.btmr = r.btmr - 12'h001;
        end
        case (r.st)
            ST_IDLE: begin
                // A request during a power or system fault waits here
                if (loc_req_in && !r.ack && !fail) begin
                    next_r.laddr = loc_addr_in;
                    next_r.lwe = loc_we_in;
                    next_r.lbyte = loc_byte_in;
                    next_r.lwdata = loc_wdata_in;
                    next_r.st = ST_REQ;
                end
            end
            ST_REQ: begin
                next_r.br = 4'h0;
                if (!fail) begin
                    next_r.br[lvl_s] = 1'b1;
                    if (bg_s[lvl_s] && !bbsy_s) begin
                        next_r.br = 4'h0;
                        next_r.bbsy = 1'b1;
                        next_r.btmr = BURST_LOAD;
                        next_r.st = ST_OWN;
                    end
                end
            end
            ST_OWN: begin
                // Bit 0 of the address goes out on the bus and also picks the byte lane
                next_r.addr = {map_sel, r.laddr[15:0]};
                next_r.am = a24_s ? map_sel[13:8] : cfg.am;
                next_r.wr = r.lwe;
                next_r.dout = r.lbyte ? {2{r.lwdata[7:0]}} : swap16(r.lwdata);
                next_r.doe = r.lwe;
                next_r.st = ST_STB;
            end
            ST_STB: begin
                next_r.as = 1'b1;
                next_r.ds = lane_sel(r.lbyte, r.laddr[0]);
                if (dtack_s || berr_s) begin
                    next_r.as = 1'b0;
                    next_r.ds = 2'b00;
                    next_r.doe = 1'b0;
                    next_r.ack = 1'b1;
                    next_r.ev[EV_BERR] = berr_s;
                    if (!r.lbyte) begin
                        next_r.rdata = swap16(vdata_s);
                    end else if (r.laddr[0]) begin
                        next_r.rdata = {8'h00, vdata_s[7:0]};
                    end else begin
                        next_r.rdata = {8'h00, vdata_s[15:8]};
                    end
                    next_r.st = ST_DONE;
                end
            end
            ST_DONE: begin
                // Bus clear and other requests are not looked at here
                if (!dtack_s && !berr_s) begin
                    if (burst_s && loc_req_in && !r.ack && r.btmr != 12'h000) begin
                        next_r.laddr = loc_addr_in;
                        next_r.lwe = loc_we_in;
                        next_r.lbyte = loc_byte_in;
                        next_r.lwdata = loc_wdata_in;
                        next_r.st = ST_OWN;
                    end else begin
                        next_r.bbsy = 1'b0;
                        next_r.ev[EV_BURST] = burst_s && r.btmr == 12'h000;
                        next_r.st = ST_IDLE;
                    end
                end
            end
            default: begin
                next_r.st = ST_IDLE;
            end
        endcase
        // Own level passes its grant on only while this end is idle, neither asking nor holding the bus
        for (int i = 0; i < 4; i++) begin
            if (2'(i) == lvl_s) begin
                next_r.bgout[i] = bg_s[i] && r.st == ST_IDLE;
            end else begin
                next_r.bgout[i] = bg_s[i];
            end
        end
        next_r.irq = 7'h00;
        if (cfg.irq_pend && cfg.irq_lvl != 3'h0) begin
            next_r.irq[cfg.irq_lvl - 3'h1] = 1'b1;
        end
        if (iack_s && iack_lvl_s == cfg.irq_lvl && cfg.irq_pend && !r.vec_oe) begin
            next_r.vec_oe = 1'b1;
            next_r.iack_done = 1'b1;
            next_r.dout = {8'h00, cfg.irq_vec};
            next_r.doe = 1'b1;
        end else if (!iack_s && r.vec_oe) begin
            next_r.vec_oe = 1'b0;
            next_r.doe = 1'b0;
        end
        next_r.dtack_o = next_r.vec_oe || swr_s || srd_s;
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign cfg.iack_done = r.iack_done;
    assign cfg.ev = r.ev;
    assign loc_ack_out = r.ack;
    assign loc_rdata_out = r.rdata;
    assign vme_bgout_out = r.bgout;
    assign vme_br_out = r.br;
    assign vme_bbsy_out = r.bbsy;
    assign vme_addr_out = r.addr;
    assign vme_am_out = r.am;
    assign vme_as_out = r.as;
    assign vme_ds_out = r.ds;
    assign vme_write_out = r.wr;
    assign vme_data_out = r.dout;
    assign vme_data_oe_out = r.doe;
    assign vme_dtack_out = r.dtack_o;
    assign vme_irq_out = r.irq;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);

    sequence grant_seen;
        r.st == ST_REQ && !fail && bg_s[lvl_s] && !bbsy_s;
    endsequence
    sequence cycle_start;
        ##1 vme_bbsy_out ##1 r.st == ST_STB;
    endsequence

    addr_low_join_a: assert property (vme_as_out |->
        vme_addr_out[15:0] == r.laddr[15:0])
        else $error("bus address low half differs from local address");
    map_window_sel_a: assert property (vme_as_out |->
        vme_addr_out[31:16] == (r.laddr[16] ? cfg.map1 : cfg.map0))
        else $error("wrong mapping register on upper address");
    am_from_reg_a: assert property (vme_as_out && !a24_s |-> vme_am_out == cfg.am)
        else $error("A32 modifier not from modifier register");
    am_from_map_a: assert property (vme_as_out && a24_s |->
        vme_am_out == vme_addr_out[29:24])
        else $error("A24 modifier not from map upper byte");
    fail_no_req_a: assert property (fail |=> vme_br_out == 4'h0)
        else $error("bus request raised during fail");
    grant_to_strobe_a: assert property (grant_seen |-> cycle_start)
        else $error("grant did not lead to an owned cycle");
    rwd_release_a: assert property (r.st == ST_DONE && !burst_s && !dtack_s
        && !berr_s |=> !vme_bbsy_out && r.st == ST_IDLE)
        else $error("bus not released after the cycle");
    burst_limit_a: assert property (r.st == ST_DONE && !dtack_s && !berr_s
        && r.btmr == 12'h000 |=> !vme_bbsy_out)
        else $error("burst hold exceeded its limit");
    timer_load_a: assert property ($rose(vme_bbsy_out) |-> r.btmr == BURST_LOAD)
        else $error("burst timer not loaded on ownership");
    pass_through_a: assert property (lvl_s != 2'h0 && $stable(lvl_s)
        |=> vme_bgout_out[0] == $past(bg_s[0]))
        else $error("unused grant level not passed through");
    ack_after_dtack_a: assert property ($rose(loc_ack_out) |->
        $past(dtack_s) || $past(berr_s))
        else $error("local cycle completed without acknowledge");
    irq_level_a: assert property (cfg.irq_pend && cfg.irq_lvl == 3'h5
        |=> vme_irq_out == 7'h10 || !cfg.irq_pend)
        else $error("interrupt not on the selected level");
endmodule

//--- hw/vmr_pkg.sv
/*
 * Shared constants and types of the bus master mapping requester.
 * Assumes a 200 MHz core clock and a small local register port.
 */
package vmr_pkg;
    localparam int CLK_MHZ = 200;
    localparam int BURST_US = 15;
    // Longest hold rounds down to whole cycles
    localparam int BURST_CYC = BURST_US * CLK_MHZ;
    localparam logic [11:0] BURST_LOAD = 12'(BURST_CYC - 1);
    localparam int AM_W = 6;
    localparam logic [2:0] OFF_MAP0 = 3'h0;
    localparam logic [2:0] OFF_MAP1 = 3'h1;
    localparam logic [2:0] OFF_AMOD = 3'h2;
    localparam logic [2:0] OFF_STAT = 3'h3;
    localparam logic [2:0] OFF_MASK = 3'h4;
    localparam logic [2:0] OFF_IRQ = 3'h5;
    localparam logic [2:0] OFF_HDATA = 3'h6;
    localparam logic [2:0] OFF_XSTAT = 3'h7;
    localparam logic [2:0] PORT_A = 3'h1;
    localparam logic [2:0] PORT_B = 3'h3;
    localparam logic [2:0] PORT_C = 3'h5;
    localparam logic [15:0] MAP_RST = 16'h0000;
    localparam logic [5:0] AM_RST = 6'h00;
    localparam logic [7:0] VEC_RST = 8'h00;
    localparam logic [2:0] LVL_RST = 3'h0;
    localparam int EV_N = 4;
    localparam int EV_HOST = 0;
    localparam int EV_FAIL = 1;
    localparam int EV_BURST = 2;
    localparam int EV_BERR = 3;
    localparam int IRQ_GO = 11;
    localparam int SB_PEND = 1;
    localparam int SB_RDY = 3;
    typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_OWN, ST_STB, ST_DONE} vmr_state_t;
endpackage

//--- hw/vmr_cfg_if.sv
/*
 * Interface between the register bank and the bus master core.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface vmr_cfg_if;
    logic [15:0] map0;
    logic [15:0] map1;
    logic [5:0] am;
    logic [2:0] irq_lvl;
    logic [7:0] irq_vec;
    logic irq_pend;
    logic iack_done;
    logic [3:0] ev;
    modport regs(output map0, map1, am, irq_lvl, irq_vec, irq_pend, input iack_done, ev);
    modport core(input map0, map1, am, irq_lvl, irq_vec, irq_pend, output iack_done, ev);
endinterface

//--- hw/vmr_sync.sv
/*
 * Two flip-flop synchroniser for a vector of pin levels.
 * Assumes each bit is a level; multi-bit groups are qualified by a strobe.
 */
`timescale 1ns/10ps
module vmr_sync import vmr_pkg::*; #(
    parameter int W = 46
) (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic [W-1:0] raw_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } vmr_sync_t;
    vmr_sync_t r;
    vmr_sync_t next_r;

    always_comb begin
        next_r.s1 = raw_in;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sync_out = r.s2;
endmodule

//--- hw/vmr_regs.sv
/*
 * Local register bank, host byte slave ports and interrupt status.
 * Assumes slave strobes and data arrive already synchronised.
 */
`timescale 1ns/10ps
module vmr_regs import vmr_pkg::*; (
    input wire logic clock_in,
    input wire logic arst_n_in,
    vmr_cfg_if.regs cfg,
    input wire logic [2:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    input wire logic slv_wr_in,
    input wire logic slv_rd_in,
    input wire logic [2:0] slv_port_in,
    input wire logic [7:0] slv_data_in,
    output logic [7:0] slv_data_out,
    output logic irq_out
);
    typedef struct packed {
        logic [15:0] map0;
        logic [15:0] map1;
        logic [5:0] am;
        logic [3:0] stat;
        logic [3:0] mask;
        logic [2:0] lvl;
        logic [7:0] vec;
        logic pend;
        logic [7:0] hdata;
        logic rdy;
        logic [7:0] xstat;
        logic [15:0] rdata;
        logic [7:0] sdata;
        logic wr_d;
        logic rd_d;
        logic irq;
    } vmr_regs_t;
    localparam vmr_regs_t RST = '{map0: MAP_RST, map1: MAP_RST, am: AM_RST,
        vec: VEC_RST, lvl: LVL_RST, default: '0};
    vmr_regs_t r;
    vmr_regs_t next_r;
    logic wr_e;
    logic rd_e;
    logic [3:0] ev;

    always_comb begin
        next_r = r;
        wr_e = slv_wr_in && !r.wr_d;
        rd_e = slv_rd_in && !r.rd_d;
        ev = cfg.ev;
        next_r.wr_d = slv_wr_in;
        next_r.rd_d = slv_rd_in;
        next_r.rdata = 16'h0000;
        next_r.sdata = 8'h00;
        if (cfg.iack_done) begin
            next_r.pend = 1'b0;
        end
        if (reg_wr_in) begin
            case (reg_addr_in)
                OFF_MAP0: next_r.map0 = reg_wdata_in;
                OFF_MAP1: next_r.map1 = reg_wdata_in;
                OFF_STAT: next_r.stat = r.stat & ~reg_wdata_in[3:0];
                OFF_MASK: next_r.mask = reg_wdata_in[3:0];
                OFF_IRQ: begin
                    next_r.vec = reg_wdata_in[7:0];
                    next_r.lvl = reg_wdata_in[10:8];
                    next_r.pend = next_r.pend | reg_wdata_in[IRQ_GO];
                end
                OFF_XSTAT: next_r.xstat = reg_wdata_in[7:0];
                default: ;
            endcase
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                OFF_MAP0: next_r.rdata = r.map0;
                OFF_MAP1: next_r.rdata = r.map1;
                OFF_AMOD: next_r.rdata = {10'h000, r.am};
                OFF_STAT: next_r.rdata = {12'h000, r.stat};
                OFF_MASK: next_r.rdata = {12'h000, r.mask};
                OFF_IRQ: next_r.rdata = {4'h0, r.pend, r.lvl, r.vec};
                OFF_HDATA: begin
                    next_r.rdata = {7'h00, r.rdy, r.hdata};
                    next_r.rdy = 1'b0;
                end
                default: next_r.rdata = {8'h00, r.xstat};
            endcase
        end
        // Host reaches only these byte ports, never local memory
        if (wr_e && slv_port_in == PORT_C) begin
            next_r.am = slv_data_in[5:0];
        end
        if (wr_e && slv_port_in == PORT_B) begin
            next_r.hdata = slv_data_in;
            next_r.rdy = 1'b1;
            ev[EV_HOST] = 1'b1;
        end
        if (rd_e && slv_port_in == PORT_A) begin
            next_r.sdata = r.xstat;
        end
        if (rd_e && slv_port_in == PORT_B) begin
            next_r.sdata[SB_PEND] = r.pend;
            next_r.sdata[SB_RDY] = r.rdy;
        end
        // Events are applied last so a set beats a clear
        next_r.stat = next_r.stat | ev;
        next_r.irq = |(r.stat & r.mask);
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            r <= RST;
        end else begin
            r <= next_r;
        end
    end

    assign cfg.map0 = r.map0;
    assign cfg.map1 = r.map1;
    assign cfg.am = r.am;
    assign cfg.irq_lvl = r.lvl;
    assign cfg.irq_vec = r.vec;
    assign cfg.irq_pend = r.pend;
    assign reg_rdata_out = r.rdata;
    assign slv_data_out = r.sdata;
    assign irq_out = r.irq;

    am_low_six_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        wr_e && slv_port_in == PORT_C |=> cfg.am == $past(slv_data_in[5:0]))
        else $error("modifier register did not take the low six bits");
endmodule

//--- test/vmr_far_model.sv
/*
 * Far side model: bus arbiter, grant chain head and host memory slave.
 * Assumes one clock shared with the design and active-high bus signals.
 */
`timescale 1ns/10ps
module vmr_far_model (
    input wire logic clock_in,
    input wire logic [3:0] br_in,
    output logic [3:0] bg_out = 4'h0,
    input wire logic as_in,
    input wire logic write_in,
    input wire logic [31:0] addr_in,
    input wire logic [5:0] am_in,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out = 16'hFFFF,
    output logic dtack_out = 1'b0,
    output logic [31:0] seen_addr_out = 32'h0,
    output logic [5:0] seen_am_out = 6'h0,
    output logic [15:0] seen_data_out = 16'h0
);
    always @(posedge clock_in) begin
        bg_out <= br_in;
        dtack_out <= as_in;
        if (as_in) begin
            seen_addr_out <= addr_in;
            seen_am_out <= am_in;
            seen_data_out <= data_in;
        end
        // Released lines toggle so a stale value can never pass as data
        data_out <= (as_in && !write_in) ? {addr_in[7:0], 8'h5A} : ~data_out;
    end
endmodule

//--- test/tb_vmr_master_top.sv
/*
 * Self-checking bench of the bus master top.
 * Assumes the far side model answers every cycle without bus error.
 */
`timescale 1ns/10ps
module tb_vmr_master_top;
    import vmr_pkg::*;
    logic clock_in = 0, arst_n_in = 0, loc_req_in = 0, loc_we_in = 0, loc_byte_in = 0;
    logic [16:0] loc_addr_in = 0;
    logic [15:0] loc_wdata_in = 0, reg_wdata_in = 0, loc_rdata_out, reg_rdata_out, vme_data_in;
    logic [2:0] reg_addr_in = 0, slv_port_in = 0, vme_iack_lvl_in = 0;
    logic reg_wr_in = 0, reg_rd_in = 0, slv_wr_in = 0, slv_rd_in = 0, vme_acfail_in = 0;
    logic vme_sysfail_in = 0, vme_bbsy_in = 0, vme_berr_in = 0, vme_iack_in = 0;
    logic [7:0] slv_data_in = 0;
    logic [3:0] pass_bg = 0, model_bg, vme_bgin_in, vme_bgout_out, vme_br_out;
    logic loc_ack_out, irq_out, vme_as_out, vme_write_out, vme_dtack_in, a24 = 0, burst = 0;
    logic [31:0] vme_addr_out, seen_addr;
    logic [5:0] vme_am_out, seen_am;
    logic [6:0] vme_irq_out;
    logic [15:0] vme_data_out, seen_data;
    int err_total = 0, n_compared = 0, bad;
    assign vme_bgin_in = model_bg | pass_bg;
    always #2.5 clock_in = ~clock_in;
    vmr_master_top vmr_master_top_inst (.clock_in, .arst_n_in, .loc_req_in, .loc_we_in,
        .loc_byte_in, .loc_addr_in, .loc_wdata_in, .loc_ack_out, .loc_rdata_out, .reg_addr_in,
        .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out,
        .a24_master_strap_in(a24), .burst_enable_strap_in(burst),
        .request_level_strap_in(2'h1), .vme_bgin_in, .vme_bgout_out, .vme_br_out,
        .vme_bbsy_in, .vme_bbsy_out(), .vme_acfail_in, .vme_sysfail_in, .vme_addr_out,
        .vme_am_out, .vme_as_out, .vme_ds_out(), .vme_write_out, .vme_data_in, .vme_data_out,
        .vme_data_oe_out(), .vme_dtack_in, .vme_berr_in, .vme_dtack_out(), .vme_irq_out,
        .vme_iack_in, .vme_iack_lvl_in, .slv_wr_in, .slv_rd_in, .slv_port_in, .slv_data_in,
        .slv_data_out());
    vmr_far_model vmr_far_model_inst (.clock_in, .br_in(vme_br_out), .bg_out(model_bg),
        .as_in(vme_as_out), .write_in(vme_write_out), .addr_in(vme_addr_out),
        .am_in(vme_am_out), .data_in(vme_data_out), .data_out(vme_data_in),
        .dtack_out(vme_dtack_in), .seen_addr_out(seen_addr), .seen_am_out(seen_am),
        .seen_data_out(seen_data));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1;
        @(posedge clock_in);
        reg_wr_in <= 0;
    endtask
    task automatic reg_rd(input logic [2:0] a, input logic [15:0] exp);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_rd_in <= 1;
        @(posedge clock_in);
        reg_rd_in <= 0;
        #1 chk(reg_rdata_out, exp);
    endtask
    // Host strobes are async levels, held past the synchroniser
    task automatic slv_wr(input logic [2:0] p, input logic [7:0] v);
        @(posedge clock_in);
        slv_port_in <= p;
        slv_data_in <= v;
        repeat (3) @(posedge clock_in);
        slv_wr_in <= 1;
        repeat (4) @(posedge clock_in);
        slv_wr_in <= 0;
        repeat (4) @(posedge clock_in);
    endtask
    task automatic wait_ack();
        repeat (200) begin
            @(posedge clock_in);
            #1;
            if (loc_ack_out === 1'b1) break;
        end
        chk(loc_ack_out, 1);
        @(posedge clock_in);
        loc_req_in <= 0;
        repeat (4) @(posedge clock_in);
    endtask
    task automatic loc(input logic [16:0] a, input logic w, b, input logic [15:0] v);
        @(posedge clock_in);
        loc_addr_in <= a;
        loc_we_in <= w;
        loc_byte_in <= b;
        loc_wdata_in <= v;
        loc_req_in <= 1;
        wait_ack();
    endtask
    task automatic t_map();
        reg_rd(OFF_MAP0, MAP_RST);
        reg_wr(OFF_MAP0, 16'hABCD);
        reg_wr(OFF_MAP1, 16'h1357);
        reg_rd(OFF_MAP1, 16'h1357);
        loc(17'h00042, 0, 0, 0);
        chk(seen_addr, 32'hABCD0042);
        chk(loc_rdata_out, 16'h5A42);
        loc(17'h10010, 0, 0, 0);
        chk(seen_addr, 32'h13570010);
        loc(17'h00044, 0, 1, 0);
        chk(loc_rdata_out[7:0], 8'h44);
        $display("test map done");
    endtask
    task automatic t_am();
        slv_wr(PORT_C, 8'hFF);
        reg_rd(OFF_AMOD, 16'h003F);
        loc(17'h00100, 1, 0, 16'h1122);
        chk(seen_am, 6'h3F);
        chk(seen_data, 16'h2211);
        chk(vme_as_out, 0);
        $display("test modifier done");
    endtask
    task automatic t_fail();
        bad = 0;
        @(posedge clock_in);
        vme_acfail_in <= 1;
        repeat (4) @(posedge clock_in);
        loc_addr_in <= 17'h00008;
        loc_we_in <= 0;
        loc_req_in <= 1;
        repeat (20) begin
            @(posedge clock_in);
            #1 bad += int'(loc_ack_out !== 1'b0 || vme_br_out !== 4'h0);
        end
        chk(bad, 0);
        @(posedge clock_in);
        vme_acfail_in <= 0;
        wait_ack();
        pass_bg <= 4'h8;
        repeat (6) @(posedge clock_in);
        chk(vme_bgout_out[3], 1);
        pass_bg <= 0;
        $display("test fail and grant done");
    endtask
    task automatic t_irq();
        reg_wr(OFF_MASK, 16'h0001);
        slv_wr(PORT_B, 8'h77);
        chk(irq_out, 1);
        reg_rd(OFF_HDATA, 16'h0177);
        reg_wr(OFF_MASK, 16'h0000);
        repeat (3) @(posedge clock_in);
        chk(irq_out, 0);
        reg_wr(OFF_MASK, 16'h0001);
        repeat (3) @(posedge clock_in);
        chk(irq_out, 1);
        reg_wr(OFF_STAT, 16'h0001);
        repeat (3) @(posedge clock_in);
        chk(irq_out, 0);
        reg_wr(OFF_IRQ, 16'h0DA5);
        repeat (3) @(posedge clock_in);
        chk(vme_irq_out, 7'h10);
        vme_iack_lvl_in <= 3'h5;
        vme_iack_in <= 1;
        repeat (4) @(posedge clock_in);
        chk(vme_data_out, 16'h00A5);
        vme_iack_in <= 0;
        repeat (4) @(posedge clock_in);
        chk(vme_irq_out, 7'h00);
        $display("test interrupt done");
    endtask
    task automatic t_strap();
        arst_n_in <= 0;
        a24 <= 1;
        burst <= 1;
        repeat (5) @(posedge clock_in);
        arst_n_in <= 1;
        repeat (3) @(posedge clock_in);
        reg_wr(OFF_MAP0, 16'h3D12);
        loc(17'h00020, 0, 0, 0);
        chk(seen_addr, 32'h3D120020);
        chk(seen_am, 6'h3D);
        loc_req_in <= 1;
        repeat (3100) @(posedge clock_in);
        wait_ack();
        reg_rd(OFF_STAT, 16'h0004);
        $display("test strap done");
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge clock_in);
        arst_n_in <= 1;
        repeat (3) @(posedge clock_in);
        t_map();
        t_am();
        t_fail();
        t_irq();
        t_strap();
        final_report();
    end
endmodule
